// >>> verilog/mbf_boot_ctrl.sv
// Boot and flash access control: boot selection, reset sequencing, pin release.
// Assumes pins from the board are asynchronous; jtagTck is a separate link clock.
//
// Operation
// - Both selects low: strap 0110, boot from eMMC.
// - Upper high, lower low, test strap low: strap 0010, boot from QSPI flash.
// - Both selects high: strap 0101, boot from SD card, default.
// - Upper low, lower high: strap 1110, unsupported, never relied on.
// - System reset low then power-on pulse puts device in reset, pins tri-stated.
// - Pull-up control low by default: pull-ups on during configuration.
// - Delay select low: standard power-on delay; high gives shorter delay.
// - Primary test port fully usable only after boot completes.
// - Both test chains form one scan chain on the connector once boot completes.
// - eMMC boot uses an 8-bit data interface.
// - High-speed SD boot starts at 3.3 V, then commands 1.8 V.
// - Open-drain configuration-done output shows configuration complete.
`timescale 1ns/1ps
`include "mbf_map.svh"
module mbf_boot_ctrl (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       power_on_reset_n,
  input  wire logic                       system_reset_n,
  input  wire logic                       boot_select_lo,
  input  wire logic                       boot_select_hi,
  input  wire logic                       testBootStrap,
  input  wire logic                       config_pullup_ctl_n,
  input  wire logic                       porDelaySelect,
  input  wire logic                       flash_serial_in,
  output logic [3:0]                      bootStrap,
  output logic                            bootFromEmmc,
  output logic                            bootFromQspi,
  output logic                            bootFromSd,
  output logic                            bootFromTest,
  output logic                            bootUnsupported,
  output logic                            pinsTristated,
  output logic                            ioPullupsOn,
  output logic                            emmcBusWide,
  output logic                            sdLowVoltage,
  output logic                            flashClkOut,
  output logic                            flashClkEnable_n,
  output logic                            flashSampled,
  output logic                            config_done_o,
  output logic                            config_done_oe_n,
  output logic                            bootComplete,
  input  wire logic                       jtagTck,
  input  wire logic                       jtagRst_n,
  input  wire logic                       jtagTdi,
  input  wire logic                       jtagTms,
  input  wire logic                       debugEnableCmd,
  output logic                            jtagTdo,
  output logic                            jtagTdoEnable_n,
  output logic                            debugPortEnabled
);

  // ----------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------
  logic [6:0] syncA;
  logic [6:0] syncB;
  logic [6:0] next_syncA;
  logic [6:0] next_syncB;

  always_comb begin
    next_syncA = {flash_serial_in, porDelaySelect, config_pullup_ctl_n, testBootStrap,
                  boot_select_hi, boot_select_lo, power_on_reset_n & system_reset_n};
    next_syncB = syncA;
    if (!rst_n) begin
      next_syncA = 7'h00;
      next_syncB = 7'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    syncA <= next_syncA;
    syncB <= next_syncB;
  end

  logic porN;
  logic srstN;
  logic selLo;
  logic selHi;
  logic testStrap;
  logic pullupN;
  logic porSel;
  logic flashIn;

  // System reset rides separately so the combined bit above is only a watch term
  logic [1:0] srstSync;
  logic [1:0] porSync;
  logic [1:0] next_srstSync;
  logic [1:0] next_porSync;

  always_comb begin
    next_srstSync = {srstSync[0], system_reset_n};
    next_porSync  = {porSync[0], power_on_reset_n};
    if (!rst_n) begin
      next_srstSync = 2'b00;
      next_porSync  = 2'b00;
    end
  end

  always_ff @(posedge core_clk) begin
    srstSync <= next_srstSync;
    porSync  <= next_porSync;
  end

  assign porN      = porSync[1];
  assign srstN     = srstSync[1];
  assign selLo     = syncB[1];
  assign selHi     = syncB[2];
  assign testStrap = syncB[3];
  assign pullupN   = syncB[4];
  assign porSel    = syncB[5];
  assign flashIn   = syncB[6];

  // ----------------------------------------------------------
  // Boot sequence
  // ----------------------------------------------------------
  mbf_pkg::mbf_state_e state;
  mbf_pkg::mbf_state_e next_state;
  mbf_pkg::mbf_src_e   src;
  mbf_pkg::mbf_src_e   next_src;
  logic [3:0]          strap;
  logic [3:0]          next_strap;
  logic [7:0]          count;
  logic [7:0]          next_count;
  logic                porPrev;
  logic                next_porPrev;
  logic                sampled;
  logic                next_sampled;

  always_comb begin
    next_state   = state;
    next_src     = src;
    next_strap   = strap;
    next_count   = count;
    next_porPrev = porN;
    next_sampled = 1'b0;
    if (!porN) begin
      next_state = mbf_pkg::MBF_ST_RESET;
    end else begin
      unique case (state)
        mbf_pkg::MBF_ST_RESET: begin
          // Selects captured only on the power-on release edge
          if (!porPrev) begin
            next_sampled = 1'b1;
            unique case ({selHi, selLo})
              2'b00: begin
                next_strap = `MBF_STRAP_EMMC;
                next_src   = mbf_pkg::MBF_SRC_EMMC;
              end
              2'b10: begin
                if (testStrap) begin
                  next_strap = `MBF_STRAP_TEST;
                  next_src   = mbf_pkg::MBF_SRC_TEST;
                end else begin
                  next_strap = `MBF_STRAP_QSPI;
                  next_src   = mbf_pkg::MBF_SRC_QSPI;
                end
              end
              2'b11: begin
                next_strap = `MBF_STRAP_SD;
                next_src   = mbf_pkg::MBF_SRC_SD;
              end
              2'b01: begin
                next_strap = `MBF_STRAP_SD_LS;
                next_src   = mbf_pkg::MBF_SRC_SD;
              end
            endcase
            next_count = porSel ? 8'(`MBF_POR_DLY_FAST_CYC)
                                : 8'(`MBF_POR_DLY_STD_CYC);
            next_state = mbf_pkg::MBF_ST_PORDLY;
          end
        end
        mbf_pkg::MBF_ST_PORDLY: begin
          if (count == 8'h00) begin
            next_state = (strap == `MBF_STRAP_SD_LS) ? mbf_pkg::MBF_ST_UNSUPP
                                                     : mbf_pkg::MBF_ST_BOOT;
            next_count = 8'(`MBF_BOOT_CYC);
          end else begin
            next_count = count - 8'h01;
          end
        end
        mbf_pkg::MBF_ST_BOOT: begin
          // Held while system reset is low so an external master owns the flash
          if (srstN) begin
            if (count == 8'h00) begin
              next_state = mbf_pkg::MBF_ST_CONFIG;
              next_count = 8'(`MBF_CFG_CYC);
            end else begin
              next_count = count - 8'h01;
            end
          end
        end
        mbf_pkg::MBF_ST_CONFIG: begin
          if (count == 8'h00) begin
            next_state = mbf_pkg::MBF_ST_RUN;
          end else begin
            next_count = count - 8'h01;
          end
        end
        mbf_pkg::MBF_ST_RUN: begin
          next_state = mbf_pkg::MBF_ST_RUN;
        end
        mbf_pkg::MBF_ST_UNSUPP: begin
          next_state = mbf_pkg::MBF_ST_UNSUPP;
        end
        default: begin
          next_state = mbf_pkg::MBF_ST_RESET;
        end
      endcase
    end
    if (!rst_n) begin
      next_state   = mbf_pkg::MBF_ST_RESET;
      next_src     = mbf_pkg::MBF_SRC_SD;
      next_strap   = `MBF_STRAP_RESET;
      next_count   = 8'h00;
      next_porPrev = 1'b0;
      next_sampled = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    state   <= next_state;
    src     <= next_src;
    strap   <= next_strap;
    count   <= next_count;
    porPrev <= next_porPrev;
    sampled <= next_sampled;
  end

  // ----------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------
  logic inReset;
  logic booting;
  logic done;
  logic next_flashClk;
  logic flashClk;
  logic next_flashSampled;

  assign inReset = (state == mbf_pkg::MBF_ST_RESET) || (state == mbf_pkg::MBF_ST_PORDLY)
                 || (state == mbf_pkg::MBF_ST_UNSUPP)
                 || (state == mbf_pkg::MBF_ST_BOOT && !srstN);
  assign booting = (state == mbf_pkg::MBF_ST_BOOT) && srstN;
  assign done    = (state == mbf_pkg::MBF_ST_RUN);

  always_comb begin
    // Flash clock toggles only while actually fetching from QSPI
    next_flashClk     = (booting && src == mbf_pkg::MBF_SRC_QSPI) ? ~flashClk : 1'b0;
    next_flashSampled = (booting && src == mbf_pkg::MBF_SRC_QSPI && flashClk) ? flashIn
                                                                             : flashSampled;
    if (!rst_n) begin
      next_flashClk     = 1'b0;
      next_flashSampled = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    flashClk     <= next_flashClk;
    flashSampled <= next_flashSampled;
  end

  assign bootStrap        = strap;
  assign bootFromEmmc     = src == mbf_pkg::MBF_SRC_EMMC;
  assign bootFromQspi     = src == mbf_pkg::MBF_SRC_QSPI;
  assign bootFromSd       = src == mbf_pkg::MBF_SRC_SD;
  assign bootFromTest     = src == mbf_pkg::MBF_SRC_TEST;
  assign bootUnsupported  = state == mbf_pkg::MBF_ST_UNSUPP;
  assign pinsTristated    = inReset;
  assign flashClkOut      = flashClk;
  assign flashClkEnable_n = !(booting && src == mbf_pkg::MBF_SRC_QSPI);
  assign ioPullupsOn      = !pullupN && !done;
  assign emmcBusWide      = bootFromEmmc && booting;
  // SD signalling begins at 3.3 V and drops to 1.8 V once the count is half spent
  assign sdLowVoltage     = (strap == `MBF_STRAP_SD) && booting
                          && count < 8'(`MBF_BOOT_CYC / 2);
  assign config_done_o    = 1'b0;
  assign config_done_oe_n = done;
  assign bootComplete     = done;

  // ----------------------------------------------------------
  // Scan chain on the link clock
  // ----------------------------------------------------------
  logic [1:0] fullSync;
  logic [1:0] next_fullSync;
  logic [1:0] tckIn;
  logic [1:0] tckIn2;
  logic [1:0] next_tckIn;
  logic [1:0] next_tckIn2;
  mbf_tap_if  tap ();

  always_comb begin
    next_fullSync = {fullSync[0], done};
    next_tckIn    = {jtagTms, jtagTdi};
    next_tckIn2   = tckIn;
    if (!jtagRst_n) begin
      next_fullSync = 2'b00;
      next_tckIn    = 2'b00;
      next_tckIn2   = 2'b00;
    end
  end

  always_ff @(posedge jtagTck) begin
    fullSync <= next_fullSync;
    tckIn    <= next_tckIn;
    tckIn2   <= next_tckIn2;
  end

  assign tap.tdi        = tckIn2[0];
  assign tap.tms        = tckIn2[1];
  assign tap.fullAccess = fullSync[1];
  assign tap.dbgCmd     = debugEnableCmd;

  mbf_scan_chain u_chain (
    .tck      (jtagTck),
    .tckRst_n (jtagRst_n),
    .tap      (tap.chain)
  );

  assign jtagTdo         = tap.tdo;
  assign jtagTdoEnable_n = tap.tdoEnable;
  assign debugPortEnabled = tap.dbgEnabled;

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  sequence s_por_release;
    !porN ##1 porN;
  endsequence

  property p_emmc_strap;
    @(posedge core_clk) disable iff (!rst_n)
      s_por_release ##0 (state == mbf_pkg::MBF_ST_RESET && !selHi && !selLo)
        |=> strap == `MBF_STRAP_EMMC;
  endproperty
  a_emmc_strap: assert property (p_emmc_strap) else $error("eMMC strap wrong");

  property p_qspi_strap;
    @(posedge core_clk) disable iff (!rst_n)
      s_por_release ##0 (state == mbf_pkg::MBF_ST_RESET && selHi && !selLo && !testStrap)
        |=> strap == `MBF_STRAP_QSPI;
  endproperty
  a_qspi_strap: assert property (p_qspi_strap) else $error("QSPI strap wrong");

  property p_sd_strap;
    @(posedge core_clk) disable iff (!rst_n)
      s_por_release ##0 (state == mbf_pkg::MBF_ST_RESET && selHi && selLo)
        |=> strap == `MBF_STRAP_SD;
  endproperty
  a_sd_strap: assert property (p_sd_strap) else $error("SD strap wrong");

  property p_unsupp_never_boots;
    @(posedge core_clk) disable iff (!rst_n)
      strap == `MBF_STRAP_SD_LS |-> !done;
  endproperty
  a_unsupp_never_boots: assert property (p_unsupp_never_boots) else $error("unsupported booted");

  property p_reset_tristate;
    @(posedge core_clk) disable iff (!rst_n)
      !porN |=> pinsTristated [*2];
  endproperty
  a_reset_tristate: assert property (p_reset_tristate) else $error("pins driven in reset");

  property p_sel_stable;
    @(posedge core_clk) disable iff (!rst_n)
      (state != mbf_pkg::MBF_ST_RESET && porN) |=> $stable(strap) || !$past(porN);
  endproperty
  a_sel_stable: assert property (p_sel_stable) else $error("strap changed mid boot");

  property p_pullup;
    @(posedge core_clk) disable iff (!rst_n)
      (!pullupN && !done) |-> ioPullupsOn;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-ups off in config");

  property p_delay;
    @(posedge core_clk) disable iff (!rst_n)
      s_por_release ##0 (state == mbf_pkg::MBF_ST_RESET && !porSel)
        |=> count == 8'(`MBF_POR_DLY_STD_CYC);
  endproperty
  a_delay: assert property (p_delay) else $error("wrong power-on delay");

  property p_done_od;
    @(posedge core_clk) disable iff (!rst_n)
      config_done_oe_n |-> state == mbf_pkg::MBF_ST_RUN && !config_done_o;
  endproperty
  a_done_od: assert property (p_done_od) else $error("done released early");

  property p_emmc_wide;
    @(posedge core_clk) disable iff (!rst_n)
      (booting && src == mbf_pkg::MBF_SRC_EMMC) |-> emmcBusWide;
  endproperty
  a_emmc_wide: assert property (p_emmc_wide) else $error("eMMC bus narrow");

endmodule : mbf_boot_ctrl

// >>> shared/mbf_map.svh
// Boot and flash access control: strap patterns, widths and timing counts.
// Assumes inclusion by bare name from design files.
`ifndef MBF_MAP_SVH
`define MBF_MAP_SVH

// ------------------------------------------------------------
// Boot strap patterns
// ------------------------------------------------------------
`define MBF_STRAP_EMMC      4'h6
`define MBF_STRAP_SD_LS     4'he
`define MBF_STRAP_QSPI      4'h2
`define MBF_STRAP_SD        4'h5
`define MBF_STRAP_TEST      4'h0
`define MBF_STRAP_RESET     4'h5

// ------------------------------------------------------------
// Widths and timing
// ------------------------------------------------------------
`define MBF_EMMC_WIDTH      8
`define MBF_CLK_PERIOD_NS   5
`define MBF_POR_DLY_STD_NS  640
`define MBF_POR_DLY_FAST_NS 160
`define MBF_POR_DLY_STD_CYC  (`MBF_POR_DLY_STD_NS / `MBF_CLK_PERIOD_NS)
`define MBF_POR_DLY_FAST_CYC (`MBF_POR_DLY_FAST_NS / `MBF_CLK_PERIOD_NS)
`define MBF_BOOT_CYC        16
`define MBF_CFG_CYC         16

`endif

// >>> shared/mbf_pkg.sv
// Boot and flash access control: shared types.
// Assumes nothing beyond a SystemVerilog compiler.
package mbf_pkg;

  typedef enum logic [1:0] {
    MBF_SRC_EMMC = 2'b00,
    MBF_SRC_QSPI = 2'b01,
    MBF_SRC_SD   = 2'b10,
    MBF_SRC_TEST = 2'b11
  } mbf_src_e;

  typedef enum logic [2:0] {
    MBF_ST_RESET   = 3'b000,
    MBF_ST_PORDLY  = 3'b001,
    MBF_ST_BOOT    = 3'b010,
    MBF_ST_CONFIG  = 3'b011,
    MBF_ST_RUN     = 3'b100,
    MBF_ST_UNSUPP  = 3'b101
  } mbf_state_e;

endpackage : mbf_pkg

// >>> shared/mbf_tap_if.sv
// Boot and flash access control: scan chain signals between top and chain module.
// Assumes both ends sit on the link clock tck.
`timescale 1ns/1ps
interface mbf_tap_if;
  logic tdi;
  logic tms;
  logic tdo;
  logic tdoEnable;
  logic fullAccess;
  logic dbgCmd;
  logic dbgEnabled;

  modport top   (output tdi, output tms, output fullAccess, output dbgCmd,
                 input tdo, input tdoEnable, input dbgEnabled);
  modport chain (input tdi, input tms, input fullAccess, input dbgCmd,
                 output tdo, output tdoEnable, output dbgEnabled);
endinterface : mbf_tap_if

// >>> verilog/mbf_scan_chain.sv
// Boot and flash access control: joined scan chain, one bit per section.
// Assumes tck is the link clock and all inputs are already on that clock.
`timescale 1ns/1ps
module mbf_scan_chain (
  input  wire logic  tck,
  input  wire logic  tckRst_n,
  mbf_tap_if.chain   tap
);

  // ----------------------------------------------------------
  // Two sections in series: programmable logic then processing system
  // ----------------------------------------------------------
  logic logicBit;
  logic sysBit;
  logic dbgEn;
  logic next_logicBit;
  logic next_sysBit;
  logic next_dbgEn;

  always_comb begin
    next_logicBit = tap.tdi;
    // Processing system section is bypassed until its boot completes
    next_sysBit = tap.fullAccess ? logicBit : 1'b0;
    next_dbgEn = dbgEn;
    if (!tap.fullAccess) begin
      next_dbgEn = 1'b0;
    end else if (tap.dbgCmd) begin
      next_dbgEn = 1'b1;
    end
    if (!tckRst_n) begin
      next_logicBit = 1'b0;
      next_sysBit   = 1'b0;
      next_dbgEn    = 1'b0;
    end
  end

  always_ff @(posedge tck) begin
    logicBit <= next_logicBit;
    sysBit   <= next_sysBit;
    dbgEn    <= next_dbgEn;
  end

  assign tap.tdo        = tap.fullAccess ? sysBit : logicBit;
  assign tap.tdoEnable  = 1'b0;
  assign tap.dbgEnabled = dbgEn;

  property p_chain_len;
    @(posedge tck) disable iff (!tckRst_n)
      tap.fullAccess && $past(tap.fullAccess) && $past(tap.fullAccess, 2)
        |-> tap.tdo == $past(tap.tdi, 2);
  endproperty
  a_chain_len: assert property (p_chain_len) else $error("chain delay wrong");

  property p_dbg_needs_boot;
    @(posedge tck) disable iff (!tckRst_n)
      !tap.fullAccess |=> !tap.dbgEnabled;
  endproperty
  a_dbg_needs_boot: assert property (p_dbg_needs_boot) else $error("debug port early");

endmodule : mbf_scan_chain

// >>> sim/mbf_board_model.sv
// Board controller model: power-on and system reset, boot selects, test strap.
// Assumes the bench clock; a released reset pin reads high through its pull-up.
`timescale 1ns/1ps
module mbf_board_model (
  input  wire logic clk,
  output logic      porN,
  output logic      srstN,
  output logic      selLo,
  output logic      selHi,
  output logic      strap
);
  initial begin
    porN  = 1'b0;
    srstN = 1'b1;
    selLo = 1'b1;
    selHi = 1'b1;
    strap = 1'b0;
  end

  // Optional system reset hold, then a power-on pulse with the new selects
  task automatic power_up(input logic hi, input logic lo, input logic tst, input logic hold);
    @(posedge clk);
    srstN <= !hold;
    @(posedge clk);
    porN  <= 1'b0;
    selHi <= hi;
    selLo <= lo;
    strap <= tst;
    repeat (4) @(posedge clk);
    porN  <= 1'b1;
  endtask : power_up

  // Selects moved after sampling; nothing else is driven
  task automatic set_sel(input logic hi, input logic lo);
    @(posedge clk);
    selHi <= hi;
    selLo <= lo;
  endtask : set_sel

  // System reset line let go; a fresh power-on pulse follows from the caller
  task automatic release_sys();
    @(posedge clk);
    srstN <= 1'b1;
  endtask : release_sys
endmodule : mbf_board_model

// >>> sim/tb.sv
// Bench for the boot and flash access controller: boot modes, delays, reset hand-over, scan chain.
// Assumes the board model in its own file and the strap map header.
`timescale 1ns/1ps
`include "mbf_map.svh"
module tb;
  logic       clk, rst_n, tck, tckEn, tckRst_n, pullupN, porSel, tdi, dbgCmd;
  logic       porN, srstN, selLo, selHi, tstStrap;
  logic [3:0] strapOut;
  logic       fEmmc, fQspi, fSd, fTest, unsupp, triSt, pullOn, wide, lowV, fclk;
  logic       doneO, doneOeN, bootComplete, tdo, tdoEnN, dbgOn, fclkEnN, fSam;
  logic       sawLowV, sawFclk, sawWide;
  int         bad_count, comparisons, cyc, n, nStd;
  logic [3:0] expS [5] = '{4'h6, 4'h2, 4'h5, 4'he, 4'h0};
  logic [2:0] inp [5] = '{3'b000, 3'b100, 3'b110, 3'b010, 3'b101};
  logic [4:0] dec [5] = '{5'h10, 5'h08, 5'h04, 5'h00, 5'h02};
  logic [15:0] pat = 16'hb4d3;

  mbf_board_model brd (.clk(clk), .porN(porN), .srstN(srstN), .selLo(selLo), .selHi(selHi),
    .strap(tstStrap));

  mbf_boot_ctrl dut_u (.core_clk(clk), .rst_n(rst_n), .power_on_reset_n(porN),
    .system_reset_n(srstN), .boot_select_lo(selLo), .boot_select_hi(selHi),
    .testBootStrap(tstStrap), .config_pullup_ctl_n(pullupN), .porDelaySelect(porSel),
    .flash_serial_in(1'b1), .bootStrap(strapOut), .bootFromEmmc(fEmmc), .bootFromQspi(fQspi),
    .bootFromSd(fSd), .bootFromTest(fTest), .bootUnsupported(unsupp), .pinsTristated(triSt),
    .ioPullupsOn(pullOn), .emmcBusWide(wide), .sdLowVoltage(lowV), .flashClkOut(fclk),
    .flashClkEnable_n(fclkEnN), .flashSampled(fSam), .config_done_o(doneO),
    .config_done_oe_n(doneOeN), .bootComplete(bootComplete), .jtagTck(tck),
    .jtagRst_n(tckRst_n), .jtagTdi(tdi), .jtagTms(1'b0), .debugEnableCmd(dbgCmd),
    .jtagTdo(tdo), .jtagTdoEnable_n(tdoEnN), .debugPortEnabled(dbgOn));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  initial tck = 1'b0;
  // Link clock stands still outside scan traffic
  always #3 tck = tckEn ? ~tck : 1'b0;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_boot(input int lim, output int cnt);
    cnt = 0;
    while (bootComplete !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
      if (lowV === 1'b1) sawLowV = 1'b1;
      if (fclk === 1'b1) sawFclk = 1'b1;
      if (wide === 1'b1) sawWide = 1'b1;
    end
  endtask : wait_boot

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    tckEn = 1'b0;
    tckRst_n = 1'b0;
    pullupN = 1'b0;
    porSel = 1'b0;
    tdi = 1'b0;
    dbgCmd = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("pullups", pullOn, 8'h1);
    for (int i = 0; i < 5; i++) begin
      sawLowV = 1'b0;
      sawFclk = 1'b0;
      sawWide = 1'b0;
      brd.power_up(inp[i][2], inp[i][1], inp[i][0], 1'b0);
      repeat (8) @(posedge clk);
      brd.set_sel(!inp[i][2], !inp[i][1]);
      wait_boot(400, n);
      check("strap", strapOut, expS[i]);
      check("unsupported", unsupp, 8'(i == 3));
      check("complete", bootComplete, 8'(i != 3));
      if (i != 3) check("decode", {fEmmc, fQspi, fSd, fTest, unsupp}, dec[i]);
      if (i < 3) check("emmc wide", sawWide, 8'(i == 0));
      if (i < 3) check("flash clock", sawFclk, 8'(i == 1));
      if (i < 3) check("low voltage", sawLowV, 8'(i == 2));
      if (i < 2) check("flash sample", fSam, 8'(i == 1));
      check("flash clock off", fclkEnN, 8'h1);
      check("done release", doneOeN, 8'(i != 3));
      check("done low", doneO, 8'h0);
      check("pullups", pullOn, 8'(i == 3));
      $display("boot mode test %0d done", i);
    end
    for (int k = 0; k < 2; k++) begin
      porSel <= k[0];
      brd.power_up(1'b1, 1'b1, 1'b0, 1'b0);
      wait_boot(400, n);
      if (k == 0) nStd = n;
    end
    check("delay gap", 8'(nStd - n), 8'(`MBF_POR_DLY_STD_CYC - `MBF_POR_DLY_FAST_CYC));
    $display("power-on delay test done");
    brd.power_up(1'b1, 1'b1, 1'b0, 1'b1);
    wait_boot(300, n);
    check("held boot", bootComplete, 8'h0);
    check("pins released", triSt, 8'h1);
    brd.release_sys();
    brd.power_up(1'b1, 1'b1, 1'b0, 1'b0);
    wait_boot(400, n);
    check("reboot", bootComplete, 8'h1);
    check("pins driven", triSt, 8'h0);
    $display("flash hand-over test done");
    tckEn = 1'b1;
    repeat (4) @(posedge tck);
    tckRst_n <= 1'b1;
    repeat (4) @(posedge tck);
    for (int i = 0; i < 16; i++) begin
      @(posedge tck);
      tdi <= pat[i];
      #1;
      if (i >= 4) check("chain out", tdo, 8'(pat[i-4]));
    end
    check("tdo enable", tdoEnN, 8'h0);
    dbgCmd <= 1'b1;
    repeat (6) @(posedge tck);
    #1;
    check("debug port", dbgOn, 8'h1);
    tckEn = 1'b0;
    $display("scan chain test done");
    finish_test();
  end
endmodule : tb
